/* hw/fcc_regs.svh */
// Register map, field positions, reset values, rate words and timing
// Assumes a 100 MHz system clock; included by its bare name
`ifndef FCC_REGS_SVH
`define FCC_REGS_SVH

// Register byte addresses
`define FCC_ADDR_CTRL      8'h00
`define FCC_ADDR_PCFG      8'h04
`define FCC_ADDR_BCFG      8'h08
`define FCC_ADDR_STAT      8'h0C

// Control register fields
`define FCC_CTRL_T1        0
`define FCC_CTRL_MAS       1
`define FCC_CTRL_SSYF      2

// Port configuration fields
`define FCC_PCFG_RXSEL_LSB 0
`define FCC_PCFG_RXSEL_MSB 3
`define FCC_PCFG_RXEN      4
`define FCC_PCFG_TXSEL_LSB 8
`define FCC_PCFG_TXSEL_MSB 9
`define FCC_PCFG_TXEN      12

// Buffer and source configuration fields
`define FCC_BCFG_RBS_LSB   0
`define FCC_BCFG_RBS_MSB   1
`define FCC_BCFG_XBS_LSB   2
`define FCC_BCFG_XBS_MSB   3
`define FCC_BCFG_RS1       4
`define FCC_BCFG_DXJA      5

// Status fields
`define FCC_STAT_FAST      0
`define FCC_STAT_SLOW      1
`define FCC_STAT_RXDRV     2
`define FCC_STAT_TXDRV     3
`define FCC_STAT_LOCK      4

// Reset values
`define FCC_RST_BIT        1'h0
`define FCC_RST_RXSEL      4'h0
`define FCC_RST_TXSEL      2'h0
`define FCC_RST_BS         2'h0
`define FCC_RST_WORD       32'h0000_0000

// Oscillator bypass codes
`define FCC_RBS_OFF        2'h3
`define FCC_XBS_BYPASS     2'h0

// Receive rate codes; odd codes are T1/J1 only
`define FCC_RX_SEL_MAX     4'h8

// Phase increments, 32-bit accumulator at 100 MHz
`define FCC_INC_16M384     32'h29F1_6B12
`define FCC_INC_12M352     32'h1F9F_01B8
`define FCC_INC_8M192      32'h14F8_B589
`define FCC_INC_6M176      32'h0FCF_80DC
`define FCC_INC_4M096      32'h0A7C_5AC5
`define FCC_INC_3M088      32'h07E7_C06E
`define FCC_INC_2M048      32'h053E_2D62
`define FCC_INC_1M544      32'h03F3_E037
`define FCC_INC_8K         32'h0005_3E2D
`define FCC_INC_NONE       32'h0000_0000

// Timing
`define FCC_CLK_NS         10
`define FCC_SYNC_FAST_NS   2000
`define FCC_SYNC_FAST_CYC  (`FCC_SYNC_FAST_NS / `FCC_CLK_NS)
`define FCC_SYNC_SLOW_NS   250000
`define FCC_SYNC_SLOW_CYC  (`FCC_SYNC_SLOW_NS / `FCC_CLK_NS)
`define FCC_CNT_MAX        16'hFFFF

`endif

/* hw/fcc_pkg.sv */
// Types shared by the clock output control block
// Assumes nothing beyond a SystemVerilog compiler
package fcc_pkg;
  typedef logic [31:0] fcc_word_t;
  typedef logic [15:0] fcc_cnt_t;
  typedef logic [3:0]  fcc_rxsel_t;
  typedef logic [1:0]  fcc_txsel_t;
endpackage

/* hw/fcc_osc_if.sv */
// Control and output of one numerically controlled clock oscillator
// Assumes both ends run on the system clock
`timescale 1ns/1ns
interface fcc_osc_if;
  fcc_pkg::fcc_word_t inc;
  logic               align;
  logic               run;
  logic               clk_lvl;
  modport ctrl (output inc, output align, output run, input clk_lvl);
  modport osc  (input inc, input align, input run, output clk_lvl);
endinterface

/* hw/fcc_dco.sv */
// Phase-accumulator clock oscillator on the system clock
// Assumes a synchronous active-high reset
`timescale 1ns/1ns
module fcc_dco (
  input  wire logic i_clk,
  input  wire logic i_rst,
  fcc_osc_if.osc    osc
);
  `include "fcc_regs.svh"

  fcc_pkg::fcc_word_t acc_q;
  fcc_pkg::fcc_word_t acc_d;

  assign acc_d = !osc.run  ? `FCC_RST_WORD :
                 osc.align ? `FCC_RST_WORD :
                 acc_q + osc.inc;
  assign osc.clk_lvl = acc_q[31];

  // Only the system clock feeds the phase, no other source
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_q <= `FCC_RST_WORD;
    end else begin
      acc_q <= acc_d;
    end
  end

  a_dco_step: assert property (@(posedge i_clk) disable iff (i_rst)
    osc.run && !osc.align |=> acc_q == $past(acc_q) + $past(osc.inc))
    else $error("oscillator phase did not advance by increment");

  a_dco_align: assert property (@(posedge i_clk) disable iff (i_rst)
    osc.run && osc.align |=> acc_q == `FCC_RST_WORD)
    else $error("oscillator phase not realigned");
endmodule // fcc_dco

/* hw/fcc_sync_mon.sv */
// Activity monitor and rate classifier for the synchronisation input
// Assumes the sync input is synchronous to the system clock
`timescale 1ns/1ns
module fcc_sync_mon (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_sync,
  input  wire fcc_pkg::fcc_cnt_t  i_slow_tmo,
  output logic                    o_edge,
  output logic                    o_fast,
  output logic                    o_slow
);
  `include "fcc_regs.svh"

  localparam fcc_pkg::fcc_cnt_t FAST_TMO = 16'(`FCC_SYNC_FAST_CYC);

  logic               sync_q;
  fcc_pkg::fcc_cnt_t  cnt_q;
  logic               fast_q;
  logic               slow_q;
  logic               rise;
  logic               fast_hit;
  logic               slow_hit;

  assign rise     = i_sync && !sync_q;
  assign fast_hit = rise && (cnt_q < FAST_TMO);
  assign slow_hit = rise && !fast_hit && (cnt_q < i_slow_tmo);
  assign o_edge   = rise;
  assign o_fast   = fast_q;
  assign o_slow   = slow_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_q <= `FCC_RST_BIT;
      cnt_q  <= `FCC_CNT_MAX;
    end else begin
      sync_q <= i_sync;
      cnt_q  <= rise ? 16'h0000 :
                (cnt_q == `FCC_CNT_MAX) ? cnt_q : cnt_q + 16'h0001;
    end
  end

  // Activity drops when no edge arrives within the window
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fast_q <= `FCC_RST_BIT;
      slow_q <= `FCC_RST_BIT;
    end else begin
      fast_q <= fast_hit ? 1'b1 :
                (rise || cnt_q >= FAST_TMO) ? 1'b0 : fast_q;
      slow_q <= slow_hit ? 1'b1 :
                (rise || cnt_q >= i_slow_tmo) ? 1'b0 : slow_q;
    end
  end

  a_fast_class: assert property (@(posedge i_clk) disable iff (i_rst)
    fast_hit |=> o_fast && !o_slow)
    else $error("fast sync clock not classified");

  a_slow_class: assert property (@(posedge i_clk) disable iff (i_rst)
    slow_hit |=> o_slow && !o_fast)
    else $error("8 kHz sync reference not classified");
endmodule // fcc_sync_mon

/* hw/fcc_top.sv */
// Clock output control: two oscillators steered onto two clock pins
// Assumes APB master on the system clock and a synchronous sync input
//
// Contract
// - Every internal clock derives from the single master reference.
// - Receive oscillator locks to an active 1.544/2.048 MHz sync clock.
// - In master mode with 8 kHz select, receive locks to 8 kHz sync.
// - E1 receive output offers 16.384, 8.192, 4.096, 2.048 MHz or 8 kHz.
// - T1/J1 receive output offers eight MHz rates or 8 kHz.
// - Output rates come from software-written port configuration bits.
// - After reset both outputs are inactive and weakly pulled high.
// - No receive clock while buffer size is 11 and source high bit 0.
// - E1 transmit output offers 16.384, 8.192, 4.096, 2.048 MHz only.
// - T1/J1 transmit output offers 12.352, 6.176, 3.088, 1.544 MHz.
// - No transmit clock with buffer bypass and jitter attenuation off.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "fcc_regs.svh"
module fcc_top #(
  parameter int P_SYNC_SLOW_TMO = `FCC_SYNC_SLOW_CYC
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_SYNC,
  output logic             O_RX_DEJIT_CLK,
  output logic             O_RX_DEJIT_CLK_OE,
  output logic             O_TX_DEJIT_CLK,
  output logic             O_TX_DEJIT_CLK_OE
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic                t1_q;
  logic                mas_q;
  logic                ssyf_q;
  fcc_pkg::fcc_rxsel_t rx_sel_q;
  logic                rx_en_q;
  fcc_pkg::fcc_txsel_t tx_sel_q;
  logic                tx_en_q;
  logic [1:0]          rbs_q;
  logic [1:0]          xbs_q;
  logic                rs1_q;
  logic                dxja_q;
  fcc_pkg::fcc_word_t  prdata_q;
  logic                rx_pin_q;
  logic                rx_oe_q;
  logic                tx_pin_q;
  logic                tx_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic               setup;
  logic               access;
  logic               wr;
  logic               hit_ctrl;
  logic               hit_pcfg;
  logic               hit_bcfg;
  logic               hit_stat;
  logic               hit;
  fcc_pkg::fcc_word_t rd_mux;
  fcc_pkg::fcc_word_t ctrl_rd;
  fcc_pkg::fcc_word_t pcfg_rd;
  fcc_pkg::fcc_word_t bcfg_rd;
  fcc_pkg::fcc_word_t stat_rd;

  assign setup    = I_PSEL && !I_PENABLE;
  assign access   = I_PSEL && I_PENABLE;
  assign hit_ctrl = I_PADDR == `FCC_ADDR_CTRL;
  assign hit_pcfg = I_PADDR == `FCC_ADDR_PCFG;
  assign hit_bcfg = I_PADDR == `FCC_ADDR_BCFG;
  assign hit_stat = I_PADDR == `FCC_ADDR_STAT;
  assign hit      = hit_ctrl || hit_pcfg || hit_bcfg || hit_stat;
  assign wr       = access && I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access && !hit;
  assign O_PRDATA  = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator control
  fcc_osc_if rx_osc ();
  fcc_osc_if tx_osc ();

  logic sync_edge;
  logic sync_fast;
  logic sync_slow;
  logic use_8k;
  logic lock_fast;
  logic lock_8k;
  logic rx_dco_off;
  logic tx_dco_off;
  logic rx_sel_ok;
  logic rx_run;
  logic tx_run;

  assign use_8k     = mas_q && ssyf_q;
  assign lock_fast  = !use_8k && sync_fast;
  assign lock_8k    = use_8k && sync_slow;
  assign rx_dco_off = (rbs_q == `FCC_RBS_OFF) && !rs1_q;
  assign tx_dco_off = (xbs_q == `FCC_XBS_BYPASS) && dxja_q;
  // T1/J1-only rates are refused in E1 mode
  assign rx_sel_ok  = (rx_sel_q <= `FCC_RX_SEL_MAX) &&
                      (t1_q || !rx_sel_q[0]);
  assign rx_run     = rx_en_q && rx_sel_ok && !rx_dco_off;
  assign tx_run     = tx_en_q && !tx_dco_off;

  assign rx_osc.run   = rx_run;
  assign rx_osc.align = sync_edge && (lock_fast || lock_8k);
  assign tx_osc.run   = tx_run;
  assign tx_osc.align = 1'b0;

  // Receive rate word by code
  always_comb begin
    unique case (rx_sel_q)
      4'h0:    rx_osc.inc = `FCC_INC_16M384;
      4'h1:    rx_osc.inc = `FCC_INC_12M352;
      4'h2:    rx_osc.inc = `FCC_INC_8M192;
      4'h3:    rx_osc.inc = `FCC_INC_6M176;
      4'h4:    rx_osc.inc = `FCC_INC_4M096;
      4'h5:    rx_osc.inc = `FCC_INC_3M088;
      4'h6:    rx_osc.inc = `FCC_INC_2M048;
      4'h7:    rx_osc.inc = `FCC_INC_1M544;
      4'h8:    rx_osc.inc = `FCC_INC_8K;
      default: rx_osc.inc = `FCC_INC_NONE;
    endcase
  end

  // Transmit rate word; the mode picks the E1 or T1/J1 family
  always_comb begin
    unique case (tx_sel_q)
      2'h0:    tx_osc.inc = t1_q ? `FCC_INC_12M352 : `FCC_INC_16M384;
      2'h1:    tx_osc.inc = t1_q ? `FCC_INC_6M176  : `FCC_INC_8M192;
      2'h2:    tx_osc.inc = t1_q ? `FCC_INC_3M088  : `FCC_INC_4M096;
      default: tx_osc.inc = t1_q ? `FCC_INC_1M544  : `FCC_INC_2M048;
    endcase
  end

  fcc_sync_mon u_sync_mon (
    .i_clk      (I_SYS_CLK),
    .i_rst      (I_SYS_RST),
    .i_sync     (I_SYNC),
    .i_slow_tmo (16'(P_SYNC_SLOW_TMO)),
    .o_edge     (sync_edge),
    .o_fast     (sync_fast),
    .o_slow     (sync_slow)
  );

  fcc_dco u_rx_dco (
    .i_clk (I_SYS_CLK),
    .i_rst (I_SYS_RST),
    .osc   (rx_osc.osc)
  );

  fcc_dco u_tx_dco (
    .i_clk (I_SYS_CLK),
    .i_rst (I_SYS_RST),
    .osc   (tx_osc.osc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data
  assign ctrl_rd = {29'h0000_0000, ssyf_q, mas_q, t1_q};
  assign pcfg_rd = {19'h0_0000, tx_en_q, 2'h0, tx_sel_q,
                    3'h0, rx_en_q, rx_sel_q};
  assign bcfg_rd = {26'h000_0000, dxja_q, rs1_q, xbs_q, rbs_q};
  assign stat_rd = {27'h000_0000, lock_fast || lock_8k, tx_oe_q,
                    rx_oe_q, sync_slow, sync_fast};
  assign rd_mux  = hit_ctrl ? ctrl_rd :
                   hit_pcfg ? pcfg_rd :
                   hit_bcfg ? bcfg_rd :
                   hit_stat ? stat_rd : `FCC_RST_WORD;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      prdata_q <= `FCC_RST_WORD;
    end else if (setup && !I_PWRITE) begin
      prdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      t1_q   <= `FCC_RST_BIT;
      mas_q  <= `FCC_RST_BIT;
      ssyf_q <= `FCC_RST_BIT;
    end else if (wr && hit_ctrl) begin
      t1_q   <= I_PWDATA[`FCC_CTRL_T1];
      mas_q  <= I_PWDATA[`FCC_CTRL_MAS];
      ssyf_q <= I_PWDATA[`FCC_CTRL_SSYF];
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rx_sel_q <= `FCC_RST_RXSEL;
      rx_en_q  <= `FCC_RST_BIT;
      tx_sel_q <= `FCC_RST_TXSEL;
      tx_en_q  <= `FCC_RST_BIT;
    end else if (wr && hit_pcfg) begin
      rx_sel_q <= I_PWDATA[`FCC_PCFG_RXSEL_MSB:`FCC_PCFG_RXSEL_LSB];
      rx_en_q  <= I_PWDATA[`FCC_PCFG_RXEN];
      tx_sel_q <= I_PWDATA[`FCC_PCFG_TXSEL_MSB:`FCC_PCFG_TXSEL_LSB];
      tx_en_q  <= I_PWDATA[`FCC_PCFG_TXEN];
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rbs_q  <= `FCC_RST_BS;
      xbs_q  <= `FCC_RST_BS;
      rs1_q  <= `FCC_RST_BIT;
      dxja_q <= `FCC_RST_BIT;
    end else if (wr && hit_bcfg) begin
      rbs_q  <= I_PWDATA[`FCC_BCFG_RBS_MSB:`FCC_BCFG_RBS_LSB];
      xbs_q  <= I_PWDATA[`FCC_BCFG_XBS_MSB:`FCC_BCFG_XBS_LSB];
      rs1_q  <= I_PWDATA[`FCC_BCFG_RS1];
      dxja_q <= I_PWDATA[`FCC_BCFG_DXJA];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pins; idle level is high with the driver off
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rx_pin_q <= 1'b1;
      rx_oe_q  <= `FCC_RST_BIT;
      tx_pin_q <= 1'b1;
      tx_oe_q  <= `FCC_RST_BIT;
    end else begin
      rx_pin_q <= rx_run ? rx_osc.clk_lvl : 1'b1;
      rx_oe_q  <= rx_run;
      tx_pin_q <= tx_run ? tx_osc.clk_lvl : 1'b1;
      tx_oe_q  <= tx_run;
    end
  end

  assign O_RX_DEJIT_CLK    = rx_pin_q;
  assign O_RX_DEJIT_CLK_OE = rx_oe_q;
  assign O_TX_DEJIT_CLK    = tx_pin_q;
  assign O_TX_DEJIT_CLK_OE = tx_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_reset_idle_high: assert property (
    $past(I_SYS_RST) |-> !O_RX_DEJIT_CLK_OE && !O_TX_DEJIT_CLK_OE &&
                         O_RX_DEJIT_CLK && O_TX_DEJIT_CLK)
    else $error("clock outputs not idle after reset");

  a_rx_off_quiet: assert property (
    rx_dco_off |=> !O_RX_DEJIT_CLK_OE && O_RX_DEJIT_CLK)
    else $error("receive clock driven while oscillator off");

  a_tx_bypass_quiet: assert property (
    tx_dco_off |=> !O_TX_DEJIT_CLK_OE && O_TX_DEJIT_CLK)
    else $error("transmit clock driven in bypass");

  a_rx_e1_rates: assert property (
    rx_run && !t1_q |-> rx_osc.inc inside {`FCC_INC_16M384,
      `FCC_INC_8M192, `FCC_INC_4M096, `FCC_INC_2M048, `FCC_INC_8K})
    else $error("receive rate not an E1 rate");

  a_rx_t1_enable: assert property (
    rx_en_q && t1_q && !rx_dco_off && rx_sel_q <= `FCC_RX_SEL_MAX
    |=> O_RX_DEJIT_CLK_OE)
    else $error("T1/J1 receive rate not accepted");

  a_tx_e1_rates: assert property (
    tx_run && !t1_q |-> tx_osc.inc inside {`FCC_INC_16M384,
      `FCC_INC_8M192, `FCC_INC_4M096, `FCC_INC_2M048})
    else $error("transmit rate not an E1 rate");

  a_tx_t1_rates: assert property (
    tx_run && t1_q |-> tx_osc.inc inside {`FCC_INC_12M352,
      `FCC_INC_6M176, `FCC_INC_3M088, `FCC_INC_1M544})
    else $error("transmit rate not a T1/J1 rate");

  a_pcfg_write: assert property (
    wr && hit_pcfg |=>
      rx_sel_q == $past(I_PWDATA[`FCC_PCFG_RXSEL_MSB:`FCC_PCFG_RXSEL_LSB]) &&
      tx_en_q == $past(I_PWDATA[`FCC_PCFG_TXEN]))
    else $error("port configuration write lost");

  a_rx_lock_fast: assert property (
    sync_edge && sync_fast && !use_8k |-> rx_osc.align ##1 !rx_osc.clk_lvl)
    else $error("receive oscillator ignored fast sync clock");

  a_rx_lock_8k: assert property (
    sync_edge && sync_slow && use_8k |-> rx_osc.align ##1 !rx_osc.clk_lvl)
    else $error("receive oscillator ignored 8 kHz reference");

  c_rx_driving: cover property (rx_run ##1 O_RX_DEJIT_CLK_OE);
  c_tx_driving: cover property (tx_run && t1_q ##1 O_TX_DEJIT_CLK_OE);
  c_rx_locked:  cover property (rx_run && rx_osc.align);
  c_bad_addr:   cover property (O_PSLVERR);
endmodule // fcc_top

/* testbench/fcc_clk_sink.sv */
// Model of the system logic that takes the two de-jittered clocks
// Assumes the pads pull an undriven clock pin weakly high
`timescale 1ns/1ns
module fcc_clk_sink (
  input  wire logic        i_clk,
  input  wire logic        i_gate,
  input  wire logic        i_rx_clk,
  input  wire logic        i_rx_oe,
  input  wire logic        i_tx_clk,
  input  wire logic        i_tx_oe,
  output logic             o_rx_wire,
  output logic             o_tx_wire,
  output logic      [15:0] o_rx_edges,
  output logic      [15:0] o_tx_edges
);
  logic rx_prev_q;
  logic tx_prev_q;
  logic gate_q;

  // Weak pull-up wins while the driver is off
  assign o_rx_wire = i_rx_oe ? i_rx_clk : 1'b1;
  assign o_tx_wire = i_tx_oe ? i_tx_clk : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Rising edges seen on each wire while the gate is open
  always_ff @(posedge i_clk) begin
    rx_prev_q <= o_rx_wire;
    tx_prev_q <= o_tx_wire;
    gate_q    <= i_gate;
    if (i_gate && !gate_q) begin
      o_rx_edges <= 16'h0000;
      o_tx_edges <= 16'h0000;
    end else if (i_gate) begin
      o_rx_edges <= o_rx_edges + {15'h0000, o_rx_wire & ~rx_prev_q};
      o_tx_edges <= o_tx_edges + {15'h0000, o_tx_wire & ~tx_prev_q};
    end
  end
endmodule // fcc_clk_sink

/* testbench/tb_top.sv */
// Self-checking bench for the clock output control block
// Assumes zero-wait APB and the register map of fcc_regs.svh
`timescale 1ns/1ns
`include "fcc_regs.svh"
`define CHK(G, E) begin tests_run++; if ((G) !== (E)) begin failures++; \
  $display("unexpected at %0t: got %0h want %0h", $time, G, E); end end
module tb_top;
  localparam int LP_TMO   = 400;
  localparam int LP_WIN   = 1000;
  localparam int LP_LIMIT = 60000;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync    = 1'b0;
  logic        gate    = 1'b0;
  logic        rx_clk, rx_oe, tx_clk, tx_oe, rx_wire, tx_wire;
  logic [15:0] rx_n, tx_n;
  int          sync_half = 0;
  int          sync_cnt  = 0;
  int          cycles    = 0;
  int          failures  = 0;
  int          tests_run = 0;
  int          rx_khz [9] = '{16384, 12352, 8192, 6176, 4096, 3088, 2048,
                              1544, 8};
  int          tx_e1  [4] = '{16384, 8192, 4096, 2048};
  int          tx_t1  [4] = '{12352, 6176, 3088, 1544};

  fcc_top #(.P_SYNC_SLOW_TMO(LP_TMO)) fcc_top_inst (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SYNC(sync), .O_RX_DEJIT_CLK(rx_clk), .O_RX_DEJIT_CLK_OE(rx_oe),
    .O_TX_DEJIT_CLK(tx_clk), .O_TX_DEJIT_CLK_OE(tx_oe));

  fcc_clk_sink fcc_clk_sink_inst (
    .i_clk(clk), .i_gate(gate), .i_rx_clk(rx_clk), .i_rx_oe(rx_oe),
    .i_tx_clk(tx_clk), .i_tx_oe(tx_oe), .o_rx_wire(rx_wire),
    .o_tx_wire(tx_wire), .o_rx_edges(rx_n), .o_tx_edges(tx_n));

  // Master reference from outside, exact rate, no drift
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // Sync source, square wave of 2*sync_half cycles, held low at zero
  always @(posedge clk) begin
    if (sync_half == 0) begin
      sync_cnt <= 0;
      sync     <= 1'b0;
    end else if (sync_cnt >= sync_half - 1) begin
      sync_cnt <= 0;
      sync     <= ~sync;
    end else begin
      sync_cnt <= sync_cnt + 1;
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LP_LIMIT) begin
      failures++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One APB transfer, then one idle cycle before the next setup
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic measure();
    gate <= 1'b1;
    repeat (LP_WIN) @(posedge clk);
    gate <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic near(input logic [15:0] n, input int khz);
    int e;
    e = khz * LP_WIN / 100000;
    return (int'(n) >= e - 2) && (int'(n) <= e + 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    `CHK(rx_oe, 1'b0)
    `CHK(tx_oe, 1'b0)
    `CHK(rx_wire, 1'b1)
    `CHK(tx_wire, 1'b1)
    `CHK(pready, 1'b1)
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0000_0000, r, e);
      `CHK(r, `FCC_RST_WORD)
    end
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0000_0000)
    wr(`FCC_ADDR_STAT, 32'hFFFF_FFFF);
    apb(1'b0, `FCC_ADDR_STAT, 32'h0000_0000, r, e);
    `CHK(r, 32'h0000_0000)
    $display("test reset done");
  endtask

  task automatic t_rx_rates(input logic t1);
    logic ok;
    wr(`FCC_ADDR_CTRL, {31'h0000_0000, t1});
    for (int c = 0; c < 9; c++) begin
      wr(`FCC_ADDR_PCFG, 32'h0000_0010 | 32'(c));
      ok = t1 | ~c[0];
      repeat (4) @(posedge clk);
      `CHK(rx_oe, ok)
      measure();
      if (!ok) `CHK(rx_n, 16'h0000)
      else if (c < 8) `CHK(near(rx_n, rx_khz[c]), 1'b1)
    end
    // Codes above the 8 kHz code are refused in both modes
    wr(`FCC_ADDR_PCFG, 32'h0000_0019);
    repeat (4) @(posedge clk);
    `CHK(rx_oe, 1'b0)
    $display("test rx rates mode %0d done", t1);
  endtask

  task automatic t_tx_rates(input logic t1);
    wr(`FCC_ADDR_CTRL, {31'h0000_0000, t1});
    for (int c = 0; c < 4; c++) begin
      wr(`FCC_ADDR_PCFG, 32'h0000_1000 | (32'(c) << 8));
      repeat (4) @(posedge clk);
      `CHK(tx_oe, 1'b1)
      measure();
      `CHK(near(tx_n, t1 ? tx_t1[c] : tx_e1[c]), 1'b1)
    end
    $display("test tx rates mode %0d done", t1);
  endtask

  task automatic t_bypass();
    wr(`FCC_ADDR_CTRL, 32'h0000_0000);
    wr(`FCC_ADDR_PCFG, 32'h0000_1016);
    wr(`FCC_ADDR_BCFG, 32'h0000_0003);
    repeat (4) @(posedge clk);
    `CHK(rx_oe, 1'b0)
    measure();
    `CHK(rx_n, 16'h0000)
    wr(`FCC_ADDR_BCFG, 32'h0000_0013);
    repeat (4) @(posedge clk);
    `CHK(rx_oe, 1'b1)
    wr(`FCC_ADDR_BCFG, 32'h0000_0020);
    repeat (4) @(posedge clk);
    `CHK(tx_oe, 1'b0)
    measure();
    `CHK(tx_n, 16'h0000)
    wr(`FCC_ADDR_BCFG, 32'h0000_0024);
    repeat (4) @(posedge clk);
    `CHK(tx_oe, 1'b1)
    wr(`FCC_ADDR_BCFG, 32'h0000_0000);
    repeat (4) @(posedge clk);
    `CHK(tx_oe, 1'b1)
    $display("test bypass done");
  endtask

  task automatic t_sync();
    logic [31:0] r;
    logic        e;
    wr(`FCC_ADDR_CTRL, 32'h0000_0000);
    wr(`FCC_ADDR_PCFG, 32'h0000_0016);
    sync_half = 30;
    repeat (400) @(posedge clk);
    apb(1'b0, `FCC_ADDR_STAT, 32'h0000_0000, r, e);
    `CHK(r[`FCC_STAT_FAST], 1'b1)
    `CHK(r[`FCC_STAT_LOCK], 1'b1)
    measure();
    // Realignment every 60 cycles leaves one rise per sync period
    `CHK(rx_n >= 16'h000F && rx_n <= 16'h0012, 1'b1)
    sync_half = 150;
    wr(`FCC_ADDR_CTRL, 32'h0000_0006);
    repeat (1000) @(posedge clk);
    apb(1'b0, `FCC_ADDR_STAT, 32'h0000_0000, r, e);
    `CHK(r[`FCC_STAT_SLOW], 1'b1)
    `CHK(r[`FCC_STAT_LOCK], 1'b1)
    wr(`FCC_ADDR_CTRL, 32'h0000_0004);
    repeat (4) @(posedge clk);
    apb(1'b0, `FCC_ADDR_STAT, 32'h0000_0000, r, e);
    `CHK(r[`FCC_STAT_LOCK], 1'b0)
    sync_half = 0;
    $display("test sync done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rx_rates(1'b0);
    t_rx_rates(1'b1);
    t_tx_rates(1'b0);
    t_tx_rates(1'b1);
    t_bypass();
    t_sync();
    wrap_up();
  end
endmodule // tb_top
